// file: bench/crtc_vcursor_sva.sv
// Assertion checker for the vertical timing and cursor section
`timescale 1ns/100ps
`default_nettype none
module crtc_vcursor_chk (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_index,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] vertical_overflow_bits,
  input wire ovf_wr,
  input wire text_mode,
  input wire line_end,
  input wire frame_start,
  input wire [9:0] scan_line,
  input wire [4:0] row_scan,
  input wire display_active,
  input wire vsync,
  input wire cursor_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rsv; reg_rd && reg_index == 8'h0a |=> reg_rdata[7:6] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_ovf; ovf_wr |-> $past(reg_wr) && $past(reg_index) <= 8'h07; endproperty
  a_ovf: assert property (p_ovf) else $error("stray low write");
  property p_high; reg_wr && reg_index > 8'h07 |=> !ovf_wr; endproperty
  a_high: assert property (p_high) else $error("index misrouted");
  property p_frame; frame_start |=> scan_line == 10'h000 && display_active; endproperty
  a_frame: assert property (p_frame) else $error("frame start wrong");
  // Guarded by reset history, since reset itself drops the level
  property p_dend; !$past(rst) && $fell(display_active) |-> $past(line_end)
    && $past(scan_line[9:8]) == {vertical_overflow_bits[6], vertical_overflow_bits[1]}; endproperty
  a_dend: assert property (p_dend) else $error("display end wrong");
  // A start value of zero raises sync on the frame start edge itself
  property p_vs; $rose(vsync) |-> ($past(line_end) || $past(frame_start))
    && scan_line[9:8] == {vertical_overflow_bits[7], vertical_overflow_bits[2]}; endproperty
  a_vs: assert property (p_vs) else $error("vsync start wrong");
  property p_row; !$past(rst) && !$stable(row_scan) |-> $past(line_end) || $past(frame_start); endproperty
  a_row: assert property (p_row) else $error("row scan moved");
  property p_gfx; !text_mode [*8] |-> !cursor_out; endproperty
  a_gfx: assert property (p_gfx) else $error("cursor in graphics");
  cover property (frame_start);
  cover property ($rose(vsync));
  cover property ($rose(cursor_out));
endmodule
bind crtc_vcursor crtc_vcursor_chk u_chk (.*);
`default_nettype wire

// file: bench/crtc_vcursor_tb_top.sv
// Self-checking bench for the vertical timing and cursor section
`timescale 1ns/100ps
`default_nettype none
module crtc_vcursor_tb_top;
  logic ref_clk, rst, reg_wr, reg_rd, text_mode, char_clk_en, line_end, frame_start, ovf_wr;
  logic [7:0] reg_index, reg_wdata, reg_rdata, vertical_overflow_bits, split_line_low, vblank_start_low;
  logic [15:0] mem_addr;
  logic [9:0] scan_line;
  logic [4:0] row_scan;
  logic display_active, vblank, vsync, cursor_out, rd_pend, seen;
  logic [7:0] expq[$];
  logic [31:0] rs;
  int errors, samples_checked, cyc, n, k, m, s;
  crtc_vcursor uut (.*);
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    samples_checked++;
    if (v !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    reg_index <= i;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] i, input logic [7:0] e);
    expq.push_back(e);
    @(posedge ref_clk);
    reg_index <= i;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task pulse(input bit fr);
    @(posedge ref_clk);
    if (fr) frame_start <= 1'b1;
    else line_end <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    line_end <= 1'b0;
    @(negedge ref_clk);
  endtask
  // Read data lands one edge after the request, so compare half a cycle later
  always @(posedge ref_clk) rd_pend <= reg_rd;
  always @(negedge ref_clk) if (rd_pend) chk("rdata", {8'h00, expq.pop_front()}, {8'h00, reg_rdata});
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    {rst, reg_wr, reg_rd, text_mode, char_clk_en, line_end, frame_start} = 7'h40;
    reg_index = 8'h00;
    reg_wdata = 8'h00;
    split_line_low = 8'h05;
    vblank_start_low = 8'h0b;
    rs = 32'h00014b0d;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (k = 9; k <= 18; k++) begin
      rs = nxt(rs);
      wr(8'(k), rs[7:0] & 8'h7f);
      rd(8'(k), rs[7:0] & ((k == 10) ? 8'h3f : 8'h7f));
    end
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h7f);
    rd(8'h13, 8'h00);
    wr(8'h07, 8'h00);
    wr(8'h11, 8'hbe);
    wr(8'h07, 8'hff);
    @(negedge ref_clk) chk("ovf", 16'h0010, {8'h00, vertical_overflow_bits});
    rd(8'h11, 8'hbe);
    wr(8'h11, 8'h0e);
    wr(8'h07, 8'h00);
    @(negedge ref_clk) chk("ovf", 16'h0000, {8'h00, vertical_overflow_bits});
    wr(8'h12, 8'h09);
    wr(8'h10, 8'h0c);
    for (k = 12; k <= 15; k++) wr(8'(k), (k % 2) ? 8'h34 : 8'h12);
    for (s = 0; s < 2; s++) begin
      wr(8'h09, s ? 8'h83 : 8'h03);
      pulse(1);
      chk("addr", 16'h1234, mem_addr);
      for (n = 1; n < 16; n++) begin
        pulse(0);
        chk("line", 16'(n), {6'h00, scan_line});
        chk("active", 16'(n <= 9), 16'(display_active));
        chk("vsync", 16'(n >= 12 && n < 14), 16'(vsync));
        if (n <= 11) chk("vblank", 16'(n == 11), 16'(vblank));
        if (n < 5) chk("row", 16'((s ? n / 2 : n) % 4), {11'h000, row_scan});
        if (n == 5) chk("split", 16'h0000, {mem_addr[15:0] | {11'h000, row_scan}});
      end
    end
    wr(8'h09, 8'h03);
    for (s = 0; s < 4; s++) for (m = 0; m < 3; m++) begin
      wr(8'h0a, (m == 1) ? 8'h21 : 8'h01);
      wr(8'h0b, {1'b0, 2'(s), 5'h02});
      @(posedge ref_clk) text_mode <= (m != 2);
      pulse(1);
      pulse(0);
      seen = 1'b0;
      repeat (10) begin
        @(posedge ref_clk) char_clk_en <= ~char_clk_en;
        @(negedge ref_clk) seen = seen | cursor_out;
      end
      chk("cursor", 16'(m == 0), 16'(seen));
    end
    close_out();
  end
endmodule
`default_nettype wire

// file: verilog/crtc_vcursor.v
// Vertical timing, row scan and text cursor section of the display timing controller
`timescale 1ns/100ps
`default_nettype none
`include "crtc_vcursor_regs.vh"
// Notes on behaviour
// - Double-scan bit 7 set halves the row scan clock so each line repeats.
// - Split line is row-height bit 6, overflow bit 4, split line low byte.
// - At the split line the memory address counter reloads with zero.
// - Blank start is row-height bit 5, overflow bit 3, blank start low byte.
// - Row height field holds lines minus one; row scan counter wraps after it.
// - Cursor-off bit 5 suppresses the cursor; graphics modes ignore cursor settings.
// - Cursor begins on the start-field line, top line of the box being zero.
// - Cursor last line is the end-field line, counted from zero at the top.
// - Skew field 6:5 delays cursor by one to four character clocks.
// - First active fetch uses the 16-bit display start address.
// - Cursor sits at the character whose address equals the 16-bit position.
// - Vsync starts at the line given by overflow bits 7,2 and the low byte.
// - Protect bit blocks writes to indices 00h-07h except overflow bit 4.
// - Vertical interrupt enable and clear bits are plain storage, no effect.
// - Vsync ends when the low four line bits match the end field.
// - Last active line is overflow bits 6,1 with the display end low byte.
// - First active line is scan line zero; software programs relative to it.
// - Reserved cursor bits read as zero.
// - Registers are reached by index then data port access.
module crtc_vcursor (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_index,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg [7:0] vertical_overflow_bits,
  output reg ovf_wr,
  input wire [7:0] split_line_low,
  input wire [7:0] vblank_start_low,
  input wire text_mode,
  input wire char_clk_en,
  input wire line_end,
  input wire frame_start,
  output reg [15:0] mem_addr,
  output reg [9:0] scan_line,
  output reg [4:0] row_scan,
  output reg display_active,
  output reg vblank,
  output reg vsync,
  output reg cursor_out
);
  reg [7:0] row_height_and_overflow_reg;
  reg [7:0] cursor_start_line_reg;
  reg [7:0] cursor_end_line_reg;
  reg [7:0] display_start_high_reg;
  reg [7:0] display_start_low_reg;
  reg [7:0] cursor_position_high_reg;
  reg [7:0] cursor_position_low_reg;
  reg [7:0] vsync_start_low_reg;
  reg [7:0] vsync_end_protect_reg;
  reg [7:0] display_end_low_reg;
  reg [15:0] row_base_reg;
  reg half_line_reg;
  reg [3:0] skew_pipe_reg;
  wire [9:0] split_line;
  wire [9:0] vblank_start;
  wire [9:0] vsync_start;
  wire [9:0] display_end;
  wire [15:0] display_start;
  wire [15:0] cursor_addr;
  wire protect;
  wire row_tick;
  wire row_wrap;
  wire cursor_raw;
  wire cursor_delayed;
  reg [7:0] rdata_next;

  // Ten-bit line values assembled from the split fields
  assign split_line = {row_height_and_overflow_reg[`BIT_SPLIT_LINE_9],
                       vertical_overflow_bits[`BIT_OVF_SPLIT_8], split_line_low};
  assign vblank_start = {row_height_and_overflow_reg[`BIT_VBLANK_START_9],
                         vertical_overflow_bits[`BIT_OVF_VBLANK_8], vblank_start_low};
  assign vsync_start = {vertical_overflow_bits[`BIT_OVF_VSYNC_9],
                        vertical_overflow_bits[`BIT_OVF_VSYNC_8], vsync_start_low_reg};
  assign display_end = {vertical_overflow_bits[`BIT_OVF_DEND_9],
                        vertical_overflow_bits[`BIT_OVF_DEND_8], display_end_low_reg};
  assign display_start = {display_start_high_reg, display_start_low_reg};
  assign cursor_addr = {cursor_position_high_reg, cursor_position_low_reg};
  assign protect = vsync_end_protect_reg[`BIT_PROTECT];

  // Double scan advances the row counter on every second line only
  assign row_tick = line_end && (!row_height_and_overflow_reg[`BIT_DOUBLE_SCAN] || half_line_reg);
  assign row_wrap = (row_scan == row_height_and_overflow_reg[4:0]);

  // Cursor match; a window with start past end shows nothing, as on legacy parts
  assign cursor_raw = text_mode && !cursor_start_line_reg[`BIT_CURSOR_OFF] &&
                      (mem_addr == cursor_addr) && display_active &&
                      (row_scan >= cursor_start_line_reg[4:0]) &&
                      (row_scan <= cursor_end_line_reg[4:0]);

  function [7:0] read_mux;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_ROW_HEIGHT_AND_OVERFLOW: read_mux = row_height_and_overflow_reg;
        `IDX_CURSOR_START_LINE: read_mux = cursor_start_line_reg & `MASK_CURSOR_START;
        `IDX_CURSOR_END_LINE: read_mux = cursor_end_line_reg & `MASK_CURSOR_END;
        `IDX_DISPLAY_START_HIGH: read_mux = display_start_high_reg;
        `IDX_DISPLAY_START_LOW: read_mux = display_start_low_reg;
        `IDX_CURSOR_POSITION_HIGH: read_mux = cursor_position_high_reg;
        `IDX_CURSOR_POSITION_LOW: read_mux = cursor_position_low_reg;
        `IDX_VSYNC_START_LOW: read_mux = vsync_start_low_reg;
        `IDX_VSYNC_END_PROTECT: read_mux = vsync_end_protect_reg;
        `IDX_DISPLAY_END_LOW: read_mux = display_end_low_reg;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  always @* begin
    rdata_next = reg_rd ? read_mux(reg_index) : reg_rdata;
  end

  // Register writes, routed by index
  always @(posedge ref_clk) begin
    if (rst) begin
      row_height_and_overflow_reg <= `RESET_REG;
      cursor_start_line_reg <= `RESET_REG;
      cursor_end_line_reg <= `RESET_REG;
      display_start_high_reg <= `RESET_REG;
      display_start_low_reg <= `RESET_REG;
      cursor_position_high_reg <= `RESET_REG;
      cursor_position_low_reg <= `RESET_REG;
      vsync_start_low_reg <= `RESET_REG;
      vsync_end_protect_reg <= `RESET_REG;
      display_end_low_reg <= `RESET_REG;
      vertical_overflow_bits <= `RESET_REG;
      ovf_wr <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_next;
      ovf_wr <= reg_wr && (reg_index <= `IDX_PROTECT_LAST) && !protect;
      if (reg_wr) begin
        case (reg_index)
          `IDX_ROW_HEIGHT_AND_OVERFLOW: row_height_and_overflow_reg <= reg_wdata;
          `IDX_CURSOR_START_LINE: cursor_start_line_reg <= reg_wdata & `MASK_CURSOR_START;
          `IDX_CURSOR_END_LINE: cursor_end_line_reg <= reg_wdata & `MASK_CURSOR_END;
          `IDX_DISPLAY_START_HIGH: display_start_high_reg <= reg_wdata;
          `IDX_DISPLAY_START_LOW: display_start_low_reg <= reg_wdata;
          `IDX_CURSOR_POSITION_HIGH: cursor_position_high_reg <= reg_wdata;
          `IDX_CURSOR_POSITION_LOW: cursor_position_low_reg <= reg_wdata;
          `IDX_VSYNC_START_LOW: vsync_start_low_reg <= reg_wdata;
          `IDX_VSYNC_END_PROTECT: vsync_end_protect_reg <= reg_wdata;
          `IDX_DISPLAY_END_LOW: display_end_low_reg <= reg_wdata;
          `IDX_PROTECT_LAST: begin
            // Split-line bit 8 stays writable so split screens work under protection
            if (protect) begin
              vertical_overflow_bits[`BIT_OVF_SPLIT_8] <= reg_wdata[`BIT_OVF_SPLIT_8];
            end else begin
              vertical_overflow_bits <= reg_wdata;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Vertical counting, first active line numbered zero
  always @(posedge ref_clk) begin
    if (rst) begin
      scan_line <= 10'h000;
      row_scan <= 5'h00;
      half_line_reg <= 1'b0;
      row_base_reg <= 16'h0000;
      mem_addr <= 16'h0000;
      display_active <= 1'b0;
      vblank <= 1'b0;
      vsync <= 1'b0;
    end else if (frame_start) begin
      scan_line <= 10'h000;
      row_scan <= 5'h00;
      half_line_reg <= 1'b0;
      row_base_reg <= display_start;
      mem_addr <= display_start;
      display_active <= 1'b1;
      vblank <= 1'b0;
      vsync <= (vsync_start == 10'h000);
    end else begin
      if (char_clk_en && display_active) begin
        mem_addr <= mem_addr + 16'h0001;
      end
      if (line_end) begin
        scan_line <= scan_line + 10'h001;
        half_line_reg <= !half_line_reg;
        if (scan_line == display_end) begin
          display_active <= 1'b0;
        end
        if (scan_line + 10'h001 == vblank_start) begin
          vblank <= 1'b1;
        end
        if (scan_line + 10'h001 == vsync_start) begin
          vsync <= 1'b1;
        end else if ((scan_line[3:0] + 4'h1) == vsync_end_protect_reg[3:0]) begin
          vsync <= 1'b0;
        end
        if (scan_line + 10'h001 == split_line) begin
          // Later rows fetch from the start of the frame buffer
          row_base_reg <= 16'h0000;
          mem_addr <= 16'h0000;
          row_scan <= 5'h00;
        end else if (row_tick) begin
          if (row_wrap) begin
            row_scan <= 5'h00;
            row_base_reg <= mem_addr;
          end else begin
            row_scan <= row_scan + 5'h01;
            mem_addr <= row_base_reg;
          end
        end else begin
          mem_addr <= row_base_reg;
        end
      end
    end
  end

  // Skew pipeline; costs four flops but lets the match align with the pixel path
  always @(posedge ref_clk) begin
    if (rst) begin
      skew_pipe_reg <= 4'h0;
    end else if (char_clk_en) begin
      skew_pipe_reg <= {skew_pipe_reg[2:0], cursor_raw};
    end
  end
  assign cursor_delayed = skew_pipe_reg[cursor_end_line_reg[6:5]];

  always @(posedge ref_clk) begin
    if (rst) begin
      cursor_out <= 1'b0;
    end else begin
      cursor_out <= cursor_delayed && text_mode;
    end
  end
endmodule
`default_nettype wire

// file: verilog/crtc_vcursor_regs.vh
// Index map, field positions and reset values of the vertical and cursor timing registers
`ifndef CRTC_VCURSOR_REGS_VH
`define CRTC_VCURSOR_REGS_VH
`define IDX_ROW_HEIGHT_AND_OVERFLOW 8'h09
`define IDX_CURSOR_START_LINE 8'h0a
`define IDX_CURSOR_END_LINE 8'h0b
`define IDX_DISPLAY_START_HIGH 8'h0c
`define IDX_DISPLAY_START_LOW 8'h0d
`define IDX_CURSOR_POSITION_HIGH 8'h0e
`define IDX_CURSOR_POSITION_LOW 8'h0f
`define IDX_VSYNC_START_LOW 8'h10
`define IDX_VSYNC_END_PROTECT 8'h11
`define IDX_DISPLAY_END_LOW 8'h12
`define IDX_PROTECT_LAST 8'h07
`define BIT_DOUBLE_SCAN 7
`define BIT_SPLIT_LINE_9 6
`define BIT_VBLANK_START_9 5
`define BIT_CURSOR_OFF 5
`define BIT_PROTECT 7
`define BIT_VINT_ENABLE 5
`define BIT_VINT_CLEAR 4
`define BIT_OVF_SPLIT_8 4
`define BIT_OVF_VBLANK_8 3
`define BIT_OVF_VSYNC_8 2
`define BIT_OVF_VSYNC_9 7
`define BIT_OVF_DEND_8 1
`define BIT_OVF_DEND_9 6
`define MASK_CURSOR_START 8'h3f
`define MASK_CURSOR_END 8'h7f
`define RESET_REG 8'h00
`endif
